/* File: shared/pimux_map.vh */
// register indices, field positions, reset values and codes of the pin mux block
`ifndef PIMUX_MAP_VH
`define PIMUX_MAP_VH

// register indices; byte address is four times the index
`define PIMUX_IDX_P0_IN_EN 30'h0000520a
`define PIMUX_IDX_P1_IN_EN 30'h0000521a
`define PIMUX_IDX_P0_LO_SEL 30'h000052a0
`define PIMUX_IDX_P0_HI_SEL 30'h000052a1
`define PIMUX_IDX_P0_IN_DATA 30'h00005200
`define PIMUX_IDX_P1_IN_DATA 30'h00005210

// reset values
`define PIMUX_RST_IN_EN 8'hff
`define PIMUX_RST_SEL 8'h00

// implemented bits of the second port input enable
`define PIMUX_P1_IN_EN_MASK 8'h0f
`define PIMUX_P1_PINS 4

// select field low bit positions, low register: pins 0..3, high: pins 4..7
`define PIMUX_FLD_PIN0_LSB 0
`define PIMUX_FLD_PIN1_LSB 2
`define PIMUX_FLD_PIN2_LSB 4
`define PIMUX_FLD_PIN3_LSB 6

// select codes
`define PIMUX_CODE_GPIO 2'h0
`define PIMUX_CODE_FUNC1 2'h1
`define PIMUX_CODE_FUNC2 2'h2
`define PIMUX_CODE_FUNC3 2'h3

// ahb constants
`define PIMUX_HTRANS_NONSEQ 2'h2
`define PIMUX_HRESP_OKAY 1'h0

`endif

/* File: src/pimux_sync.v */
// two flip-flop synchroniser for pad levels
`timescale 1ns/1ps
`default_nettype none
module pimux_sync #(
  parameter WIDTH = 8
) (
  // clock and reset
  input wire ref_clk,
  input wire srst,
  // asynchronous levels in, synchronised levels out
  input wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] meta_reg;
  reg [WIDTH-1:0] sync_reg;

  always @(posedge ref_clk) begin
    if (srst) begin
      meta_reg <= {WIDTH{1'b0}};
      sync_reg <= {WIDTH{1'b0}};
    end else begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
    end
  end

  assign sync_out = sync_reg;
endmodule
`default_nettype wire

/* File: src/pimux_field_dec.v */
// decodes one two-bit pin function field into one-hot selects
`timescale 1ns/1ps
`default_nettype none
`include "pimux_map.vh"
module pimux_field_dec (
  // field code
  input wire [1:0] code,
  // one-hot select, bit n set for code n
  output wire [3:0] sel
);
  assign sel[0] = (code == `PIMUX_CODE_GPIO);
  assign sel[1] = (code == `PIMUX_CODE_FUNC1);
  assign sel[2] = (code == `PIMUX_CODE_FUNC2);
  assign sel[3] = (code == `PIMUX_CODE_FUNC3);
endmodule
`default_nettype wire

/* File: src/pimux_top.v */
// port input enable gating and port 0 pin function mux with ahb-lite registers
`timescale 1ns/1ps
`default_nettype none
`include "pimux_map.vh"

// Contract
// [R1] input enable 1: pin level, driven or not, shows in port input data register
// [R2] input enable 0: pin level blocked, port input data bit reads 0
// [R3] all input enable bits reset to 1, register value 0xff for port 0, 0x0f for the second port
// [R4] second port input enable: low four bits only, upper bits read 0
// [R5] input enable bit y gates only pin y of its port
// [R6] pin3 field bits 7:6: port, timer ext clock, regulator monitor, lcd oscillator
// [R7] pin2 field bits 5:4: port, uart serial clock, clock output a, regulator monitor
// [R8] pin1 field bits 3:2: port, uart transmit; codes 2 and 3 reserved
// [R9] pin0 field bits 1:0: port, uart receive; codes 2 and 3 reserved
// [R10] pin7 field bits 7:6: port, inverted buzzer, spi0 data out; 3 reserved
// [R11] pin6 field bits 5:4: port, buzzer, spi0 data in; 3 reserved
// [R12] pin5 field bits 3:2: port or spi0 slave select; 3 reserved
// [R13] pin5 code 1: timer0 b, compare out or capture in by timer mode
// [R14] pin4 field bits 1:0: port or timer0 a by mode; 2 and 3 reserved
// [R15] all select fields reset to 0, general port; fields read and write
// [R16] selected peripheral drives pad output and enable, receives pad input
module pimux_top (
  // clock and reset
  input wire ref_clk,
  input wire srst,
  // ahb-lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg hreadyout,
  output reg hresp,
  output reg [31:0] hrdata,
  // port 0 pads
  input wire [7:0] pad0_in,
  output reg [7:0] pad0_out,
  output reg [7:0] pad0_oe,
  // port 1 pads
  input wire [3:0] pad1_in,
  output reg [3:0] pad1_out,
  output reg [3:0] pad1_oe,
  // general port drive
  input wire [7:0] gpio0_out,
  input wire [7:0] gpio0_oe,
  input wire [3:0] gpio1_out,
  input wire [3:0] gpio1_oe,
  // port input data register contents
  output reg [7:0] port0_input_data,
  output reg [3:0] port1_input_data,
  // uart
  output reg uart_receive_in,
  input wire uart_transmit_out,
  output reg uart_serial_clock,
  // clock generator, regulator, lcd
  input wire clock_output_a,
  input wire regulator_monitor_out,
  input wire lcd_low_freq_osc_out,
  // sixteen bit pwm timer channel 0
  output reg timer_external_clock_in,
  input wire timer0_capture_mode,
  input wire timer0_compare_out_a,
  input wire timer0_compare_out_b,
  output reg timer0_capture_in_a,
  output reg timer0_capture_in_b,
  // sound generator
  input wire buzzer_out,
  input wire buzzer_out_inverted,
  // spi channel 0
  output reg spi0_slave_select_n,
  output reg spi0_data_in,
  input wire spi0_data_out
);
  // registers
  reg [7:0] port0_input_enable_reg;
  reg [7:0] port0_input_enable_next;
  reg [7:0] port1_input_enable_reg;
  reg [7:0] port1_input_enable_next;
  reg [7:0] port0_low_pin_select_reg;
  reg [7:0] port0_low_pin_select_next;
  reg [7:0] port0_high_pin_select_reg;
  reg [7:0] port0_high_pin_select_next;
  // pending write from the address phase
  reg wr_pend_reg;
  reg [29:0] wr_idx_reg;
  reg [7:0] rd_value;
  wire addr_phase;
  wire [7:0] pad0_sync;
  wire [3:0] pad1_sync;
  // four one-hot selects per pin, pin n at bits 4n+3..4n
  wire [31:0] sel_vec;
  wire [15:0] sel_fields;
  reg [7:0] mux_out;
  reg [7:0] mux_oe;
  wire [7:0] gp_sel;

  pimux_sync #(
    .WIDTH(8)
  ) u_sync0 (
    .ref_clk(ref_clk),
    .srst(srst),
    .async_in(pad0_in),
    .sync_out(pad0_sync)
  );

  pimux_sync #(
    .WIDTH(`PIMUX_P1_PINS)
  ) u_sync1 (
    .ref_clk(ref_clk),
    .srst(srst),
    .async_in(pad1_in),
    .sync_out(pad1_sync)
  );

  assign addr_phase = hsel & hready & (htrans == `PIMUX_HTRANS_NONSEQ);

  // data phase write into the next values
  always @* begin
    port0_input_enable_next = port0_input_enable_reg;
    port1_input_enable_next = port1_input_enable_reg;
    port0_low_pin_select_next = port0_low_pin_select_reg;
    port0_high_pin_select_next = port0_high_pin_select_reg;
    if (wr_pend_reg) begin
      case (wr_idx_reg)
        `PIMUX_IDX_P0_IN_EN: begin
          port0_input_enable_next = hwdata[7:0];
        end
        `PIMUX_IDX_P1_IN_EN: begin
          port1_input_enable_next = hwdata[7:0] & `PIMUX_P1_IN_EN_MASK; // R4
        end
        `PIMUX_IDX_P0_LO_SEL: begin
          port0_low_pin_select_next = hwdata[7:0]; // R15
        end
        `PIMUX_IDX_P0_HI_SEL: begin
          port0_high_pin_select_next = hwdata[7:0]; // R15
        end
        default: begin
          port0_input_enable_next = port0_input_enable_reg;
        end
      endcase
    end
  end

  // read mux on next values so a read right after a write sees it
  always @* begin
    case (haddr[31:2])
      `PIMUX_IDX_P0_IN_EN: begin
        rd_value = port0_input_enable_next;
      end
      `PIMUX_IDX_P1_IN_EN: begin
        rd_value = port1_input_enable_next & `PIMUX_P1_IN_EN_MASK; // R4
      end
      `PIMUX_IDX_P0_LO_SEL: begin
        rd_value = port0_low_pin_select_next; // R15
      end
      `PIMUX_IDX_P0_HI_SEL: begin
        rd_value = port0_high_pin_select_next; // R15
      end
      `PIMUX_IDX_P0_IN_DATA: begin
        rd_value = port0_input_data;
      end
      `PIMUX_IDX_P1_IN_DATA: begin
        rd_value = {4'h0, port1_input_data};
      end
      default: begin
        rd_value = 8'h00;
      end
    endcase
  end

  always @(posedge ref_clk) begin
    if (srst) begin
      port0_input_enable_reg <= `PIMUX_RST_IN_EN; // R3
      port1_input_enable_reg <= `PIMUX_RST_IN_EN & `PIMUX_P1_IN_EN_MASK; // R3
      port0_low_pin_select_reg <= `PIMUX_RST_SEL; // R15
      port0_high_pin_select_reg <= `PIMUX_RST_SEL; // R15
      wr_pend_reg <= 1'b0;
      wr_idx_reg <= 30'h00000000;
      hreadyout <= 1'b1;
      hresp <= `PIMUX_HRESP_OKAY;
      hrdata <= 32'h00000000;
    end else begin
      port0_input_enable_reg <= port0_input_enable_next;
      port1_input_enable_reg <= port1_input_enable_next;
      port0_low_pin_select_reg <= port0_low_pin_select_next;
      port0_high_pin_select_reg <= port0_high_pin_select_next;
      wr_pend_reg <= addr_phase & hwrite;
      if (addr_phase) begin
        wr_idx_reg <= haddr[31:2];
      end
      hreadyout <= 1'b1;
      hresp <= `PIMUX_HRESP_OKAY;
      if (addr_phase & ~hwrite) begin
        hrdata <= {24'h000000, rd_value};
      end
    end
  end

  // pins 7..4 above pins 3..0, two bits per pin
  assign sel_fields = {port0_high_pin_select_reg, port0_low_pin_select_reg};

  // one decoder per pin field
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_dec
      pimux_field_dec u_dec (
        .code(sel_fields[2*gi+1:2*gi]),
        .sel(sel_vec[4*gi+3:4*gi])
      );
    end
  endgenerate

  // reserved codes fall back to the general port
  assign gp_sel[0] = sel_vec[0] | sel_vec[2] | sel_vec[3]; // R9
  assign gp_sel[1] = sel_vec[4] | sel_vec[6] | sel_vec[7]; // R8
  assign gp_sel[2] = sel_vec[8]; // R7
  assign gp_sel[3] = sel_vec[12]; // R6
  assign gp_sel[4] = sel_vec[16] | sel_vec[18] | sel_vec[19]; // R14
  assign gp_sel[5] = sel_vec[20] | sel_vec[23]; // R12
  assign gp_sel[6] = sel_vec[24] | sel_vec[27]; // R11
  assign gp_sel[7] = sel_vec[28] | sel_vec[31]; // R10

  // pad drive per pin
  always @* begin
    mux_out = 8'h00;
    mux_oe = 8'h00;
    // pin0: receive input, never driven by the uart
    mux_out[0] = gp_sel[0] & gpio0_out[0]; // R9
    mux_oe[0] = gp_sel[0] & gpio0_oe[0]; // R9
    // pin1: uart transmit
    mux_out[1] = (gp_sel[1] & gpio0_out[1]) | (sel_vec[5] & uart_transmit_out); // R8 R16
    mux_oe[1] = (gp_sel[1] & gpio0_oe[1]) | sel_vec[5]; // R8 R16
    // pin2: serial clock is an input, clock a and monitor are outputs
    mux_out[2] = (gp_sel[2] & gpio0_out[2]) | (sel_vec[10] & clock_output_a)
      | (sel_vec[11] & regulator_monitor_out); // R7 R16
    mux_oe[2] = (gp_sel[2] & gpio0_oe[2]) | sel_vec[10] | sel_vec[11]; // R7 R16
    // pin3: external clock is an input
    mux_out[3] = (gp_sel[3] & gpio0_out[3]) | (sel_vec[14] & regulator_monitor_out)
      | (sel_vec[15] & lcd_low_freq_osc_out); // R6 R16
    mux_oe[3] = (gp_sel[3] & gpio0_oe[3]) | sel_vec[14] | sel_vec[15]; // R6 R16
    // pin4: timer a drives only in compare mode
    mux_out[4] = (gp_sel[4] & gpio0_out[4])
      | (sel_vec[17] & ~timer0_capture_mode & timer0_compare_out_a); // R14 R16
    mux_oe[4] = (gp_sel[4] & gpio0_oe[4]) | (sel_vec[17] & ~timer0_capture_mode); // R14
    // pin5: timer b drives only in compare mode, slave select is an input
    mux_out[5] = (gp_sel[5] & gpio0_out[5])
      | (sel_vec[21] & ~timer0_capture_mode & timer0_compare_out_b); // R13 R16
    mux_oe[5] = (gp_sel[5] & gpio0_oe[5]) | (sel_vec[21] & ~timer0_capture_mode); // R13 R12
    // pin6: buzzer out, spi data in is an input
    mux_out[6] = (gp_sel[6] & gpio0_out[6]) | (sel_vec[25] & buzzer_out); // R11 R16
    mux_oe[6] = (gp_sel[6] & gpio0_oe[6]) | sel_vec[25]; // R11 R16
    // pin7: inverted buzzer or spi data out
    mux_out[7] = (gp_sel[7] & gpio0_out[7]) | (sel_vec[29] & buzzer_out_inverted)
      | (sel_vec[30] & spi0_data_out); // R10 R16
    mux_oe[7] = (gp_sel[7] & gpio0_oe[7]) | sel_vec[29] | sel_vec[30]; // R10 R16
  end

  // registered pad drive, peripheral inputs and input data
  always @(posedge ref_clk) begin
    if (srst) begin
      pad0_out <= 8'h00;
      pad0_oe <= 8'h00;
      pad1_out <= 4'h0;
      pad1_oe <= 4'h0;
      port0_input_data <= 8'h00;
      port1_input_data <= 4'h0;
      uart_receive_in <= 1'b1;
      uart_serial_clock <= 1'b1;
      timer_external_clock_in <= 1'b0;
      timer0_capture_in_a <= 1'b0;
      timer0_capture_in_b <= 1'b0;
      spi0_slave_select_n <= 1'b1;
      spi0_data_in <= 1'b0;
    end else begin
      pad0_out <= mux_out;
      pad0_oe <= mux_oe;
      pad1_out <= gpio1_out;
      pad1_oe <= gpio1_oe;
      // per-bit gating, pad level seen whatever drives it
      port0_input_data <= pad0_sync & port0_input_enable_reg; // R1 R2 R5
      port1_input_data <= pad1_sync & port1_input_enable_reg[3:0]; // R1 R2 R5
      // unselected peripheral inputs rest at their idle level
      uart_receive_in <= sel_vec[1] ? pad0_sync[0] : 1'b1; // R9 R16
      uart_serial_clock <= sel_vec[9] ? pad0_sync[2] : 1'b1; // R7 R16
      timer_external_clock_in <= sel_vec[13] & pad0_sync[3]; // R6 R16
      timer0_capture_in_a <= sel_vec[17] & timer0_capture_mode & pad0_sync[4]; // R14
      timer0_capture_in_b <= sel_vec[21] & timer0_capture_mode & pad0_sync[5]; // R13
      spi0_slave_select_n <= sel_vec[22] ? pad0_sync[5] : 1'b1; // R12 R16
      spi0_data_in <= sel_vec[26] & pad0_sync[6]; // R11 R16
    end
  end
endmodule
`default_nettype wire

/* File: bench/pimux_far.sv */
// pad and peripheral model on the far side of the pin mux
`timescale 1ns/1ps
`default_nettype none
module pimux_far (
  // clock
  input wire logic ref_clk,
  // pad drive from the block and from the board
  input wire logic [7:0] pad0_out, pad0_oe, ext0,
  input wire logic [3:0] pad1_out, pad1_oe, ext1,
  // pad levels seen by the block
  output logic [7:0] pad0_in,
  output logic [3:0] pad1_in,
  // peripheral outputs
  output logic uart_transmit_out, clock_output_a, regulator_monitor_out, lcd_low_freq_osc_out,
  output logic timer0_compare_out_a, timer0_compare_out_b, buzzer_out, buzzer_out_inverted,
  output logic spi0_data_out
);
  logic [8:0] cnt_reg = 9'h000;
  always @(posedge ref_clk) cnt_reg <= cnt_reg + 9'h001;
  // a driven pin shows its driver, else the board level
  assign pad0_in = (pad0_out & pad0_oe) | (ext0 & ~pad0_oe);
  assign pad1_in = (pad1_out & pad1_oe) | (ext1 & ~pad1_oe);
  // outputs are counter bits mixed in differing patterns, changing at differing rates
  assign {uart_transmit_out, clock_output_a, regulator_monitor_out, lcd_low_freq_osc_out,
    timer0_compare_out_a, timer0_compare_out_b, buzzer_out, buzzer_out_inverted,
    spi0_data_out} = cnt_reg ^ {cnt_reg[4:0], cnt_reg[8:5]};
endmodule
`default_nettype wire

/* File: bench/pimux_asserts.sv */
// port-level checker of the pin mux block
`timescale 1ns/1ps
`default_nettype none
`include "pimux_map.vh"
module pimux_asserts (
  // clock, reset and bus
  input wire logic ref_clk, srst, hsel, hwrite, hready,
  input wire logic [31:0] haddr, hwdata,
  input wire logic [1:0] htrans,
  // pads and port data
  input wire logic [7:0] pad0_in, pad0_out, pad0_oe, gpio0_out, gpio0_oe, port0_input_data,
  input wire logic [3:0] pad1_in, port1_input_data,
  // peripherals
  input wire logic uart_receive_in, uart_transmit_out, uart_serial_clock, clock_output_a,
  input wire logic regulator_monitor_out, lcd_low_freq_osc_out, timer_external_clock_in,
  input wire logic timer0_capture_mode, timer0_compare_out_a, timer0_compare_out_b,
  input wire logic timer0_capture_in_a, timer0_capture_in_b, buzzer_out, buzzer_out_inverted,
  input wire logic spi0_slave_select_n, spi0_data_in, spi0_data_out
);
  logic wp_reg;
  logic [29:0] wa_reg;
  logic [7:0] en0_reg, en1_reg, lo_reg, hi_reg, eo, eoe;
  logic [2:0] age_reg;
  wire ok = age_reg == 3'h4;
  // shadow of the registers, fed by observed writes
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      {wp_reg, age_reg, en0_reg, en1_reg, lo_reg, hi_reg} <= {4'h0, 16'hffff, 16'h0000};
    end else begin
      wp_reg <= hsel && hready && htrans == `PIMUX_HTRANS_NONSEQ && hwrite;
      wa_reg <= haddr[31:2];
      if (!ok) age_reg <= age_reg + 3'h1;
      if (wp_reg) begin
        case (wa_reg)
          `PIMUX_IDX_P0_IN_EN: en0_reg <= hwdata[7:0];
          `PIMUX_IDX_P1_IN_EN: en1_reg <= hwdata[7:0];
          `PIMUX_IDX_P0_LO_SEL: lo_reg <= hwdata[7:0];
          `PIMUX_IDX_P0_HI_SEL: hi_reg <= hwdata[7:0];
          default: ;
        endcase
      end
    end
  end
  // expected pad drive from the shadow selects
  always_comb begin
    {eo, eoe} = {gpio0_out, gpio0_oe};
    if (lo_reg[1:0] == 2'h1) eoe[0] = 1'b0;
    if (lo_reg[3:2] == 2'h1) {eo[1], eoe[1]} = {uart_transmit_out, 1'b1};
    if (lo_reg[5:4] == 2'h1) eoe[2] = 1'b0;
    if (lo_reg[5:4] > 2'h1) begin
      {eo[2], eoe[2]} = {lo_reg[4] ? regulator_monitor_out : clock_output_a, 1'b1};
    end
    if (lo_reg[7:6] == 2'h1) eoe[3] = 1'b0;
    if (lo_reg[7:6] > 2'h1) begin
      {eo[3], eoe[3]} = {lo_reg[6] ? lcd_low_freq_osc_out : regulator_monitor_out, 1'b1};
    end
    if (hi_reg[1:0] == 2'h1) {eo[4], eoe[4]} = {timer0_compare_out_a, !timer0_capture_mode};
    if (hi_reg[3:2] == 2'h1) {eo[5], eoe[5]} = {timer0_compare_out_b, !timer0_capture_mode};
    if (hi_reg[3:2] == 2'h2) eoe[5] = 1'b0;
    if (hi_reg[5:4] == 2'h1) {eo[6], eoe[6]} = {buzzer_out, 1'b1};
    if (hi_reg[5:4] == 2'h2) eoe[6] = 1'b0;
    if (hi_reg[7:6] == 2'h1) {eo[7], eoe[7]} = {buzzer_out_inverted, 1'b1};
    if (hi_reg[7:6] == 2'h2) {eo[7], eoe[7]} = {spi0_data_out, 1'b1};
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  property p_rst_idle;
    @(posedge ref_clk) disable iff (1'b0)
    srst |=> pad0_oe == 8'h00 && uart_receive_in && spi0_slave_select_n && !timer0_capture_in_a;
  endproperty
  chk_rst_idle: assert property (p_rst_idle) else $error("reset state wrong");
  chk_in0_gate: assert property (
    ok |-> port0_input_data == ($past(pad0_in, 3) & $past(en0_reg))) else $error("port 0 data");
  chk_in1_gate: assert property (
    ok |-> port1_input_data == ($past(pad1_in, 3) & $past(en1_reg[3:0])))
    else $error("port 1 data");
  chk_pad_oe: assert property (
    ok |-> pad0_oe == $past(eoe)) else $error("pad enable");
  chk_pad_out: assert property (
    ok |-> (pad0_out & pad0_oe) == ($past(eo) & $past(eoe))) else $error("pad level");
  chk_uart_in: assert property (
    ok |-> uart_receive_in == ($past(lo_reg[1:0]) == 2'h1 ? $past(pad0_in[0], 3) : 1'b1))
    else $error("uart receive");
  chk_clk_ins: assert property (
    ok |-> uart_serial_clock == ($past(lo_reg[5:4]) == 2'h1 ? $past(pad0_in[2], 3) : 1'b1)
    && timer_external_clock_in == ($past(lo_reg[7:6]) == 2'h1 ? $past(pad0_in[3], 3) : 1'b0))
    else $error("clock inputs");
  chk_capture_in: assert property (
    ok && $past(timer0_capture_mode) |->
    timer0_capture_in_a == ($past(hi_reg[1:0]) == 2'h1 ? $past(pad0_in[4], 3) : 1'b0)
    && timer0_capture_in_b == ($past(hi_reg[3:2]) == 2'h1 ? $past(pad0_in[5], 3) : 1'b0))
    else $error("capture inputs");
  chk_spi_ins: assert property (
    ok |-> spi0_slave_select_n == ($past(hi_reg[3:2]) == 2'h2 ? $past(pad0_in[5], 3) : 1'b1)
    && spi0_data_in == ($past(hi_reg[5:4]) == 2'h2 ? $past(pad0_in[6], 3) : 1'b0))
    else $error("spi inputs");
  cov_spi_out: cover property (ok && hi_reg[7:6] == 2'h2 && pad0_oe[7]);
  cov_capture: cover property (ok && timer0_capture_mode && hi_reg[1:0] == 2'h1);
  cov_gated: cover property (ok && en0_reg != 8'hff && port0_input_data != 8'h00);
endmodule
bind pimux_top pimux_asserts i_chk (.*);
`default_nettype wire

/* File: bench/tb_top.sv */
// self-checking bench of the pin mux block
`timescale 1ns/1ps
`default_nettype none
`include "pimux_map.vh"
module tb_top;
  logic ref_clk = 1'b0, srst = 1'b1, hsel = 1'b0, hwrite = 1'b0, timer0_capture_mode = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0;
  logic [7:0] gpio0_out = 8'h00, gpio0_oe = 8'h00, ext0 = 8'h00;
  logic [3:0] gpio1_out = 4'h0, gpio1_oe = 4'h0, ext1 = 4'h0;
  wire logic hready, hreadyout, hresp, uart_receive_in, uart_serial_clock, timer_external_clock_in;
  wire logic timer0_capture_in_a, timer0_capture_in_b, spi0_slave_select_n, spi0_data_in;
  wire logic uart_transmit_out, clock_output_a, regulator_monitor_out, lcd_low_freq_osc_out;
  wire logic timer0_compare_out_a, timer0_compare_out_b, buzzer_out, buzzer_out_inverted;
  wire logic spi0_data_out;
  wire logic [31:0] hrdata;
  wire logic [7:0] pad0_in, pad0_out, pad0_oe, port0_input_data;
  wire logic [3:0] pad1_in, pad1_out, pad1_oe, port1_input_data;
  int n_fail = 0, n_checks = 0;
  assign hready = hreadyout;
  always #12.5 ref_clk = ~ref_clk;
  pimux_top i_dut (.*);
  pimux_far i_far (.*);
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic ahb(input logic [29:0] idx, input logic is_wr, input logic [7:0] d,
    output logic [31:0] q);
    @(posedge ref_clk);
    {hsel, htrans, hwrite, haddr} <= {1'b1, `PIMUX_HTRANS_NONSEQ, is_wr, idx, 2'b00};
    do @(posedge ref_clk); while (hready !== 1'b1);
    {hsel, htrans, hwdata} <= {3'h0, 24'h0, d};
    do @(posedge ref_clk); while (hready !== 1'b1);
    q = hrdata;
  endtask
  task automatic wr(input logic [29:0] idx, input logic [7:0] d);
    logic [31:0] q;
    ahb(idx, 1'b1, d, q);
  endtask
  task automatic rd(input string nm, input logic [29:0] idx, input logic [7:0] e);
    logic [31:0] q;
    ahb(idx, 1'b0, 8'h00, q);
    chk(nm, q, {24'h0, e});
    chk("hresp", {31'h0, hresp}, {31'h0, `PIMUX_HRESP_OKAY});
  endtask
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_fail++;
    give_verdict;
  end
  initial begin
    repeat (10) @(posedge ref_clk);
    srst <= 1'b0;
    rd("p0 enable", `PIMUX_IDX_P0_IN_EN, 8'hff);
    rd("p1 enable", `PIMUX_IDX_P1_IN_EN, 8'h0f);
    rd("low select", `PIMUX_IDX_P0_LO_SEL, 8'h00);
    rd("high select", `PIMUX_IDX_P0_HI_SEL, 8'h00);
    rd("unmapped", 30'h00005300, 8'h00);
    wr(`PIMUX_IDX_P1_IN_EN, 8'hf6);
    rd("p1 enable", `PIMUX_IDX_P1_IN_EN, 8'h06);
    $display("test registers done");
    // every code on every field, timer in both modes
    for (int c = 0; c < 8; c++) begin
      wr(`PIMUX_IDX_P0_LO_SEL, {4{c[1:0]}});
      wr(`PIMUX_IDX_P0_HI_SEL, {4{c[1:0]}});
      rd("low select", `PIMUX_IDX_P0_LO_SEL, {4{c[1:0]}});
      rd("high select", `PIMUX_IDX_P0_HI_SEL, {4{c[1:0]}});
      {timer0_capture_mode, gpio0_oe} <= {c[2], c[0] ? 8'hf0 : 8'h0f};
      for (int k = 0; k < 12; k++) begin
        @(posedge ref_clk);
        {ext0, gpio0_out} <= {ext0 + 8'h35, ~ext0};
      end
    end
    $display("test pin functions done");
    wr(`PIMUX_IDX_P0_LO_SEL, 8'h00);
    wr(`PIMUX_IDX_P0_HI_SEL, 8'h00);
    {gpio0_oe, gpio0_out, ext0} <= {8'h0f, 8'h05, 8'hc0};
    {gpio1_oe, gpio1_out, ext1} <= {4'h3, 4'h1, 4'hc};
    wr(`PIMUX_IDX_P0_IN_EN, 8'h5c);
    repeat (5) @(posedge ref_clk);
    chk("p0 input data", {24'h0, port0_input_data}, 32'h44);
    chk("p1 input data", {28'h0, port1_input_data}, 32'h4);
    chk("p1 pad drive", {24'h0, pad1_oe, pad1_out}, 32'h31);
    rd("p0 data reg", `PIMUX_IDX_P0_IN_DATA, 8'h44);
    $display("test input enable done");
    give_verdict;
  end
endmodule
`default_nettype wire
